// >>> gptu_pkg.sv
// Purpose: Shared constants and types for the general purpose timer unit.
// Assumes: 16-bit register port, word addressed.
// Notes:   Prescaler base rates are derived from the fastest documented count period.
package gptu_pkg;

  localparam int TW     = 16;
  localparam int DW     = 16;
  localparam int AW     = 5;
  localparam int NTMR   = 5;
  localparam int NIRQ   = 6;

  // Timer slots: first module aux a, core, aux b; second module aux, core
  localparam int IDX_AUX_A = 0;
  localparam int IDX_CORE1 = 1;
  localparam int IDX_AUX_B = 2;
  localparam int IDX_AUX2  = 3;
  localparam int IDX_CORE2 = 4;
  localparam int IDX_CAP   = 5;

  // Register map, word addresses
  localparam logic [AW-1:0] ADDR_CON_BASE = 5'h00;
  localparam logic [AW-1:0] ADDR_CNT_BASE = 5'h05;
  localparam logic [AW-1:0] ADDR_CAPTURE_RELOAD_REGISTER   = 5'h0A;
  localparam logic [AW-1:0] ADDR_IRQ_BASE = 5'h0B;

  // Timer control word fields
  localparam int CON_PSC_LSB  = 0;
  localparam int CON_PSC_W    = 3;
  localparam int CON_MODE_LSB = 3;
  localparam int CON_POL_BIT  = 5;
  localparam int CON_RUN_BIT  = 6;
  localparam int CON_DOWN_BIT = 7;
  localparam int CON_AUX_BIT  = 8;
  localparam int CON_ROLE_LSB = 9;
  localparam int CON_TRIG_LSB = 11;
  localparam int CON_CLR_BIT  = 13;

  // Interrupt control word fields
  localparam int IRQ_PRIO_LSB = 0;
  localparam int IRQ_PRIO_W   = 4;
  localparam int IRQ_EN_BIT   = 6;
  localparam int IRQ_FLAG_BIT = 7;
  localparam int IRQ_W        = 8;

  // Fastest count periods, given at the reference CPU rate
  localparam int REF_CPU_MHZ   = 20;
  localparam int FIRST_TIMER_MODULE_MIN_NS   = 400;
  localparam int SECOND_TIMER_MODULE_MIN_NS   = 200;
  localparam int FIRST_TIMER_MODULE_BASE_DIV = FIRST_TIMER_MODULE_MIN_NS * REF_CPU_MHZ / 1000;
  localparam int SECOND_TIMER_MODULE_BASE_DIV = SECOND_TIMER_MODULE_MIN_NS * REF_CPU_MHZ / 1000;
  localparam logic [3:0] FIRST_TIMER_MODULE_SH = 4'($clog2(FIRST_TIMER_MODULE_BASE_DIV));
  localparam logic [3:0] SECOND_TIMER_MODULE_SH = 4'($clog2(SECOND_TIMER_MODULE_BASE_DIV));
  localparam int PSC_W = $clog2(FIRST_TIMER_MODULE_BASE_DIV) + (1 << CON_PSC_W);

  typedef enum logic [1:0] {
    MODE_TIMER   = 2'b00,
    MODE_GATED   = 2'b01,
    MODE_COUNTER = 2'b10
  } gptu_mode_t;

  typedef enum logic [1:0] {
    ROLE_TIMER   = 2'b00,
    ROLE_RELOAD  = 2'b01,
    ROLE_CAPTURE = 2'b10
  } gptu_role_t;

  // Reload trigger for aux timers; capture edge select for second module
  typedef enum logic [1:0] {
    TRIG_NONE     = 2'b00,
    TRIG_OTL_RISE = 2'b01,
    TRIG_OTL_FALL = 2'b10,
    TRIG_PIN      = 2'b11
  } gptu_trig_t;

endpackage

// >>> gptu_timer.sv
// Purpose: One 16-bit up/down timer cell with load and wrap detection.
// Assumes: Load has priority over counting.
// Notes:   Wrap pulse is combinational from the count pulse, not from the load.
`timescale 1ns/1ps
module gptu_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         inc_i,
  input  wire logic         down_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  // State
  output logic      [W-1:0] cnt_o,
  output logic              wrap_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    wrap_o = inc_i & (down_i ? (cnt_q == '0) : (cnt_q == '1));
    cnt_d  = cnt_q;
    if (load_i) begin
      cnt_d = load_val_i;
    end else if (inc_i) begin
      cnt_d = down_i ? cnt_q - 1'b1 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt_o = cnt_q;

endmodule // gptu_timer

// >>> gptu_top.sv
// Purpose: General purpose timer unit, two modules with five timers.
// Assumes: Pins synchronous to ref_clk_i; register read data one cycle after the strobe.
// Notes:   Interrupt request outputs are flag AND enable; priority is held for the controller.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Five 16-bit timers: three in the first module, two in the second.
// RQ2 - Timers run alone or are clocked by the core timer of their module.
// RQ3 - First module timers each select timer, gated timer or counter mode.
// RQ4 - Timer mode counts prescaled clock; counter mode counts pin events.
// RQ5 - Gated mode counts prescaled clock only while the pin level enables it.
// RQ6 - First module fastest rate is one count per eight clocks.
// RQ7 - Every timer counts up or down as software selects.
// RQ8 - First core timer direction may be flipped by its direction pin.
// RQ9 - First core wrap toggles its latch, driven out and clocking aux timers.
// RQ10 - First module aux timer may act as capture or reload; then it stops.
// RQ11 - Capture role copies the first core timer on a pin event.
// RQ12 - Reload role loads the core timer on a pin or latch transition.
// RQ13 - Two aux timers reloading on opposite transitions alternate, giving PWM.
// RQ14 - Second module fastest rate is one count per four clocks.
// RQ15 - Second core wrap toggles its latch, driven out and clocking aux.
// RQ16 - Second core wrap pulses the capture/compare clock, optionally reloads.
// RQ17 - Capture pin transition copies second aux timer; optional clear.
// RQ18 - Each timer and capture has flag, enable and sixteen-level priority.
// RQ19 - Timer wraps and capture events set their request flags.
// RQ20 - Reset clears timers, capture register and latches; all timers stopped.
module gptu_top
  import gptu_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  // Register port
  input  wire logic [gptu_pkg::AW-1:0]  reg_addr_i,
  input  wire logic [gptu_pkg::DW-1:0]  reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [gptu_pkg::DW-1:0]  reg_rdata_o,
  // Pins
  input  wire logic [2:0]               timer_gate_count_input_i,
  input  wire logic                     first_direction_input_pin_i,
  input  wire logic                     capture_input_pin_i,
  output logic                          first_toggle_output_pin_o,
  output logic                          second_toggle_output_pin_o,
  // To capture/compare unit and interrupt controller
  output logic                          cc_clock_pulse_o,
  output logic      [gptu_pkg::NIRQ-1:0] irq_req_o
);

  import gptu_pkg::*;

  logic [DW-1:0]     con_q [NTMR];
  logic [DW-1:0]     con_d [NTMR];
  logic [IRQ_W-1:0]  irq_q [NIRQ];
  logic [IRQ_W-1:0]  irq_d [NIRQ];
  logic [TW-1:0]     capture_reload_register_q;
  logic [TW-1:0]     capture_reload_register_d;
  logic              otl1_q;
  logic              otl1_d;
  logic              otl2_q;
  logic              otl2_d;
  logic [3:0]        pin_q;
  logic [3:0]        pin_d;
  logic [PSC_W-1:0]  psc_q;
  logic [PSC_W-1:0]  psc_d;
  logic [DW-1:0]     rdata_q;
  logic [DW-1:0]     rdata_d;
  logic              cc_q;
  logic              cc_d;
  logic [NIRQ-1:0]   irqreq_q;
  logic [NIRQ-1:0]   irqreq_d;

  logic [NTMR-1:0]   inc;
  logic [NTMR-1:0]   down;
  logic [NTMR-1:0]   load;
  logic [NTMR-1:0]   wrap;
  logic [TW-1:0]     lval [NTMR];
  logic [TW-1:0]     cnt  [NTMR];
  logic [NTMR-1:0]   wr_cnt;
  logic [3:0]        pins;
  logic [3:0]        rise;
  logic [3:0]        fall;
  logic              otl_rise;
  logic              otl_fall;
  logic              rl_a;
  logic              rl_b;
  logic              cap2;
  logic              fast1;
  logic              fast2;
  logic [NIRQ-1:0]   flag_set;
  gptu_role_t        role [3];

  function automatic logic tick_at(input logic [PSC_W-1:0] p, input logic [3:0] sh);
    logic [PSC_W:0] m;
    m = ({{PSC_W{1'b0}}, 1'b1} << sh) - 1'b1;
    return ((p & m[PSC_W-1:0]) == '0);
  endfunction

  function automatic logic trig_hit(input gptu_trig_t t, input logic r, input logic f,
                                    input logic p);
    logic hit;
    hit = 1'b0;
    case (t)
      TRIG_OTL_RISE: hit = r;
      TRIG_OTL_FALL: hit = f;
      TRIG_PIN:      hit = p;
      default:       hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Five identical timer cells
  for (genvar g = 0; g < NTMR; g++) begin : g_tmr
    gptu_timer #(.W(TW)) u_tmr (
      .clk_i      (ref_clk_i),
      .rst_i      (rst_i),
      .inc_i      (inc[g]),
      .down_i     (down[g]),
      .load_i     (load[g]),
      .load_val_i (lval[g]),
      .cnt_o      (cnt[g]),
      .wrap_o     (wrap[g])
    ); // [RQ1]
  end

  assign pins     = {capture_input_pin_i, timer_gate_count_input_i};
  assign rise     = pins & ~pin_q;
  assign fall     = ~pins & pin_q;
  assign otl_rise = wrap[IDX_CORE1] & ~otl1_q;
  assign otl_fall = wrap[IDX_CORE1] & otl1_q;
  assign fast1    = tick_at(psc_q, FIRST_TIMER_MODULE_SH);
  assign fast2    = tick_at(psc_q, SECOND_TIMER_MODULE_SH);
  assign flag_set = {cap2, wrap};

  // Count pulses, directions and loads for all timers
  always_comb begin : count_ctl
    logic [DW-1:0]  cfg;
    logic           tick;
    logic           evt;
    logic           gate;
    logic [3:0]     sh;
    gptu_trig_t     ctrig;
    cfg   = '0;
    tick  = 1'b0;
    evt   = 1'b0;
    gate  = 1'b0;
    sh    = '0;
    ctrig = TRIG_NONE;
    inc   = '0;
    down  = '0;
    for (int k = 0; k < NTMR; k++) begin
      wr_cnt[k] = reg_wr_i && (reg_addr_i == ADDR_CNT_BASE + AW'(k));
    end
    for (int i = 0; i < 3; i++) begin
      cfg     = con_q[i];
      role[i] = (i == IDX_CORE1) ? ROLE_TIMER : gptu_role_t'(cfg[CON_ROLE_LSB +: 2]);
      sh      = FIRST_TIMER_MODULE_SH + {1'b0, cfg[CON_PSC_LSB +: CON_PSC_W]};
      tick    = tick_at(psc_q, sh); // [RQ4] [RQ6]
      gate    = pins[i] ^ cfg[CON_POL_BIT];
      evt     = cfg[CON_POL_BIT] ? fall[i] : rise[i];
      down[i] = cfg[CON_DOWN_BIT]; // [RQ7]
      if (!cfg[CON_RUN_BIT] || role[i] != ROLE_TIMER) begin
        inc[i] = 1'b0; // [RQ10] [RQ20]
      end else if (i != IDX_CORE1 && cfg[CON_AUX_BIT]) begin
        inc[i] = wrap[IDX_CORE1]; // [RQ2] [RQ9]
      end else begin
        case (gptu_mode_t'(cfg[CON_MODE_LSB +: 2]))
          MODE_TIMER:   inc[i] = tick; // [RQ3] [RQ4]
          MODE_GATED:   inc[i] = tick & gate; // [RQ5]
          MODE_COUNTER: inc[i] = evt; // [RQ3] [RQ4]
          default:      inc[i] = 1'b0;
        endcase
      end
    end
    // Core direction may be flipped by the direction pin
    down[IDX_CORE1] = con_q[IDX_CORE1][CON_DOWN_BIT]
                      ^ (con_q[IDX_CORE1][CON_AUX_BIT] & first_direction_input_pin_i); // [RQ8]
    // Second module
    cfg             = con_q[IDX_CORE2];
    sh              = SECOND_TIMER_MODULE_SH + {1'b0, cfg[CON_PSC_LSB +: CON_PSC_W]};
    inc[IDX_CORE2]  = cfg[CON_RUN_BIT] & tick_at(psc_q, sh); // [RQ14]
    down[IDX_CORE2] = cfg[CON_DOWN_BIT]; // [RQ7]
    cfg             = con_q[IDX_AUX2];
    sh              = SECOND_TIMER_MODULE_SH + {1'b0, cfg[CON_PSC_LSB +: CON_PSC_W]};
    inc[IDX_AUX2]   = cfg[CON_RUN_BIT]
                      & (cfg[CON_AUX_BIT] ? wrap[IDX_CORE2] : tick_at(psc_q, sh)); // [RQ2] [RQ15]
    down[IDX_AUX2]  = cfg[CON_DOWN_BIT];
    ctrig           = gptu_trig_t'(cfg[CON_TRIG_LSB +: 2]);
    cap2            = (ctrig == TRIG_OTL_RISE && rise[3])
                      || (ctrig == TRIG_OTL_FALL && fall[3])
                      || (ctrig == TRIG_PIN && (rise[3] || fall[3])); // [RQ17]
    // Reload sources for the first core timer
    rl_a = (role[IDX_AUX_A] == ROLE_RELOAD)
           && trig_hit(gptu_trig_t'(con_q[IDX_AUX_A][CON_TRIG_LSB +: 2]), otl_rise, otl_fall,
                       rise[IDX_AUX_A]); // [RQ12]
    rl_b = (role[IDX_AUX_B] == ROLE_RELOAD)
           && trig_hit(gptu_trig_t'(con_q[IDX_AUX_B][CON_TRIG_LSB +: 2]), otl_rise, otl_fall,
                       rise[IDX_AUX_B]); // [RQ12] [RQ13]
    for (int k = 0; k < NTMR; k++) begin
      load[k] = wr_cnt[k];
      lval[k] = reg_wdata_i;
    end
    if (!wr_cnt[IDX_CORE1] && (rl_a || rl_b)) begin
      load[IDX_CORE1] = 1'b1;
      lval[IDX_CORE1] = rl_a ? cnt[IDX_AUX_A] : cnt[IDX_AUX_B]; // [RQ12] [RQ13]
    end
    for (int a = 0; a < 3; a += 2) begin
      if (!wr_cnt[a] && role[a] == ROLE_CAPTURE && rise[a]) begin
        load[a] = 1'b1;
        lval[a] = cnt[IDX_CORE1]; // [RQ11]
      end
    end
    if (!wr_cnt[IDX_AUX2] && cap2 && con_q[IDX_AUX2][CON_CLR_BIT]) begin
      load[IDX_AUX2] = 1'b1;
      lval[IDX_AUX2] = '0; // [RQ17]
    end
    if (!wr_cnt[IDX_CORE2] && wrap[IDX_CORE2] && con_q[IDX_CORE2][CON_AUX_BIT]) begin
      load[IDX_CORE2] = 1'b1;
      lval[IDX_CORE2] = capture_reload_register_q; // [RQ16]
    end
  end

  // Register file, latches, flags and read data
  always_comb begin : reg_ctl
    con_d    = con_q;
    irq_d    = irq_q;
    capture_reload_register_d = capture_reload_register_q;
    otl1_d   = otl1_q ^ wrap[IDX_CORE1]; // [RQ9]
    otl2_d   = otl2_q ^ wrap[IDX_CORE2]; // [RQ15]
    pin_d    = pins;
    psc_d    = psc_q + 1'b1;
    cc_d     = wrap[IDX_CORE2]; // [RQ16]
    rdata_d  = '0;
    if (cap2) begin
      capture_reload_register_d = cnt[IDX_AUX2]; // [RQ17]
    end
    for (int k = 0; k < NTMR; k++) begin
      if (reg_wr_i && reg_addr_i == ADDR_CON_BASE + AW'(k)) begin
        con_d[k] = reg_wdata_i;
      end
    end
    if (reg_wr_i && reg_addr_i == ADDR_CAPTURE_RELOAD_REGISTER && !cap2) begin
      capture_reload_register_d = reg_wdata_i;
    end
    for (int k = 0; k < NIRQ; k++) begin
      if (reg_wr_i && reg_addr_i == ADDR_IRQ_BASE + AW'(k)) begin
        irq_d[k] = reg_wdata_i[IRQ_W-1:0]; // [RQ18]
      end
      // Hardware set wins over a software clear in the same cycle
      if (flag_set[k]) begin
        irq_d[k][IRQ_FLAG_BIT] = 1'b1; // [RQ19]
      end
      irqreq_d[k] = irq_q[k][IRQ_FLAG_BIT] & irq_q[k][IRQ_EN_BIT]; // [RQ18]
    end
    if (reg_rd_i) begin
      for (int k = 0; k < NTMR; k++) begin
        if (reg_addr_i == ADDR_CON_BASE + AW'(k)) rdata_d = con_q[k];
        if (reg_addr_i == ADDR_CNT_BASE + AW'(k)) rdata_d = cnt[k];
      end
      for (int k = 0; k < NIRQ; k++) begin
        if (reg_addr_i == ADDR_IRQ_BASE + AW'(k)) rdata_d = {{(DW-IRQ_W){1'b0}}, irq_q[k]};
      end
      if (reg_addr_i == ADDR_CAPTURE_RELOAD_REGISTER) rdata_d = capture_reload_register_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      con_q    <= '{default: '0}; // [RQ20]
      irq_q    <= '{default: '0};
      capture_reload_register_q <= '0; // [RQ20]
      otl1_q   <= 1'b0; // [RQ20]
      otl2_q   <= 1'b0;
      pin_q    <= '0;
      psc_q    <= '0;
      rdata_q  <= '0;
      cc_q     <= 1'b0;
      irqreq_q <= '0;
    end else begin
      con_q    <= con_d;
      irq_q    <= irq_d;
      capture_reload_register_q <= capture_reload_register_d;
      otl1_q   <= otl1_d;
      otl2_q   <= otl2_d;
      pin_q    <= pin_d;
      psc_q    <= psc_d;
      rdata_q  <= rdata_d;
      cc_q     <= cc_d;
      irqreq_q <= irqreq_d;
    end
  end

  assign reg_rdata_o                = rdata_q;
  assign first_toggle_output_pin_o  = otl1_q;
  assign second_toggle_output_pin_o = otl2_q;
  assign cc_clock_pulse_o           = cc_q;
  assign irq_req_o                  = irqreq_q;

  chk_otl_toggle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wrap[IDX_CORE1] |=> first_toggle_output_pin_o != $past(first_toggle_output_pin_o)) // [RQ9]
    else $error("first toggle latch missed a wrap");
  chk_fast_rate1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fast1 |=> !fast1 [*7] ##1 fast1) // [RQ6]
    else $error("first module base tick not every eight clocks");
  chk_fast_rate2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fast2 |=> !fast2 [*3] ##1 fast2) // [RQ14]
    else $error("second module base tick not every four clocks");
  chk_cc_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wrap[IDX_CORE2] |=> cc_clock_pulse_o && second_toggle_output_pin_o != $past(otl2_q)) // [RQ16]
    else $error("second core wrap not passed on");
  chk_aux_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (role[IDX_AUX_B] == ROLE_CAPTURE && rise[IDX_AUX_B] && !wr_cnt[IDX_AUX_B])
    |=> cnt[IDX_AUX_B] == $past(cnt[IDX_CORE1])) // [RQ11]
    else $error("aux capture did not copy core value");
  chk_aux_stopped: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (role[IDX_AUX_B] != ROLE_TIMER && !load[IDX_AUX_B]) |=> $stable(cnt[IDX_AUX_B])) // [RQ10]
    else $error("aux timer counted while in capture or reload role");
  chk_core_reload: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rl_a && !wr_cnt[IDX_CORE1]) |=> cnt[IDX_CORE1] == $past(cnt[IDX_AUX_A])) // [RQ12]
    else $error("core timer not reloaded from aux timer");
  chk_capture_reload_register_copy: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cap2 |=> capture_reload_register_q == $past(cnt[IDX_AUX2])) // [RQ17]
    else $error("capture register did not take aux value");
  chk_irq_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wrap[IDX_CORE2] && irq_q[IDX_CORE2][IRQ_EN_BIT]) |=> ##1 irq_req_o[IDX_CORE2]) // [RQ19]
    else $error("timer wrap did not raise its request");
  chk_dir_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (inc[IDX_CORE1] && !load[IDX_CORE1] && con_q[IDX_CORE1][CON_AUX_BIT]
     && first_direction_input_pin_i && !con_q[IDX_CORE1][CON_DOWN_BIT])
    |=> cnt[IDX_CORE1] == $past(cnt[IDX_CORE1]) - 16'h0001) // [RQ8]
    else $error("direction pin did not reverse core count");
  chk_reset_clear: assert property (@(posedge ref_clk_i)
    $past(rst_i) |-> (cnt[IDX_CORE1] == '0 && capture_reload_register_q == '0 && !otl1_q && !otl2_q)) // [RQ20]
    else $error("state not cleared by reset");

endmodule // gptu_top

// >>> gptu_pins.sv
// Purpose: Far side pin model driving gate/count, direction and capture inputs.
// Assumes: Pins change by non-blocking assignment just after a rising clock edge.
// Notes:   Pulses are two cycles high and two low so edge detection sees each one.
`timescale 1ns/1ps
module gptu_pins (
  // Clock
  input  wire logic       ref_clk_i,
  // Pins towards the timer unit
  output logic      [2:0] gate_o,
  output logic            dir_o,
  output logic            cap_o
);
  initial begin
    gate_o = 3'h0;
    dir_o  = 1'b0;
    cap_o  = 1'b0;
  end

  task automatic set_gate(input int i, input logic v);
    @(posedge ref_clk_i);
    gate_o[i] <= v;
  endtask

  task automatic pulse_gate(input int i);
    set_gate(i, 1'b1);
    @(posedge ref_clk_i);
    set_gate(i, 1'b0);
    @(posedge ref_clk_i);
  endtask

  task automatic pulse_cap();
    @(posedge ref_clk_i);
    cap_o <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    cap_o <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic set_dir(input logic v);
    @(posedge ref_clk_i);
    dir_o <= v;
  endtask
endmodule // gptu_pins

// >>> test_general_purpose_timer_unit.sv
// Purpose: Self-checking bench for the timer unit through its register port and pins.
// Assumes: Count windows are bounded by two control writes, a multiple of the tick period.
// Notes:   Writing a control word of zero stops a timer so its count can be read at rest.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module test_general_purpose_timer_unit;
  import gptu_pkg::*;
  localparam logic [15:0] RUN  = 16'(1 << CON_RUN_BIT);
  localparam logic [15:0] DOWN = 16'(1 << CON_DOWN_BIT);
  localparam logic [15:0] AUXS = 16'(1 << CON_AUX_BIT);
  localparam logic [15:0] GATD = 16'(1 << CON_MODE_LSB);
  localparam logic [15:0] CNTR = 16'(2 << CON_MODE_LSB);
  localparam logic [15:0] RLD  = 16'(1 << CON_ROLE_LSB);
  localparam logic [15:0] CAPT = 16'(2 << CON_ROLE_LSB);
  localparam logic [15:0] TRGR = 16'(1 << CON_TRIG_LSB);
  localparam logic [15:0] TRGP = 16'(3 << CON_TRIG_LSB);
  localparam logic [15:0] TRGF = 16'(2 << CON_TRIG_LSB);
  localparam logic [15:0] CLRC = 16'(1 << CON_CLR_BIT);

  logic            ref_clk_i;
  logic            rst_i;
  logic [AW-1:0]   reg_addr_i;
  logic [DW-1:0]   reg_wdata_i;
  logic            reg_wr_i;
  logic            reg_rd_i;
  logic [DW-1:0]   reg_rdata_o;
  logic [2:0]      gate;
  logic            dir;
  logic            cap;
  logic            out1;
  logic            out2;
  logic            cc_pulse;
  logic [NIRQ-1:0] irq;
  logic [DW-1:0]   rd_v;
  int              n_fail;
  int              checks_done;
  int              n_cc;

  gptu_top u_gptu_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .timer_gate_count_input_i(gate),
    .first_direction_input_pin_i(dir), .capture_input_pin_i(cap),
    .first_toggle_output_pin_o(out1), .second_toggle_output_pin_o(out2),
    .cc_clock_pulse_o(cc_pulse), .irq_req_o(irq)
  );
  gptu_pins u_gptu_pins (.ref_clk_i(ref_clk_i), .gate_o(gate), .dir_o(dir), .cap_o(cap));

  initial ref_clk_i = 1'b0;
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (cc_pulse === 1'b1) n_cc++;
  end

  function automatic logic [AW-1:0] cn(input int i);
    return ADDR_CNT_BASE + AW'(i);
  endfunction
  function automatic logic [AW-1:0] cc(input int i);
    return ADDR_CON_BASE + AW'(i);
  endfunction
  function automatic logic [AW-1:0] iq(input int i);
    return ADDR_IRQ_BASE + AW'(i);
  endfunction

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask

  // Runs a timer for exactly n clock edges, then stops it
  task automatic win(input int i, input logic [DW-1:0] c, input int n);
    wr(cc(i), c);
    repeat (n - 2) @(posedge ref_clk_i);
    wr(cc(i), 16'h0000);
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    test_done();
  end

  initial begin
    rst_i = 1'b1; reg_addr_i = '0; reg_wdata_i = '0; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1 `CHK({out1, out2, irq}, 8'h00)
    for (int a = 0; a <= 16; a++) begin
      rd(AW'(a)); `CHK(rd_v, 16'h0000)
    end
    wr(5'h1F, 16'hFFFF); rd(5'h1F); `CHK(rd_v, 16'h0000)
    repeat (40) @(posedge ref_clk_i);
    rd(cn(IDX_CORE1)); `CHK(rd_v, 16'h0000)
    // Prescaled counting rates and direction
    win(IDX_CORE1, RUN, 80); rd(cn(IDX_CORE1)); `CHK(rd_v, 16'h000A)
    win(IDX_CORE2, RUN, 80); rd(cn(IDX_CORE2)); `CHK(rd_v, 16'h0014)
    wr(cn(IDX_AUX2), 16'h0100);
    win(IDX_AUX2, RUN | DOWN, 80); rd(cn(IDX_AUX2)); `CHK(rd_v, 16'h00EC)
    wr(cn(IDX_CORE1), 16'h0100); u_gptu_pins.set_dir(1'b1);
    win(IDX_CORE1, RUN | AUXS, 80); rd(cn(IDX_CORE1)); `CHK(rd_v, 16'h00F6)
    u_gptu_pins.set_dir(1'b0);
    // Gated and counter modes
    u_gptu_pins.set_gate(0, 1'b1);
    win(IDX_AUX_A, RUN | GATD, 80); rd(cn(IDX_AUX_A)); `CHK(rd_v, 16'h000A)
    u_gptu_pins.set_gate(0, 1'b0);
    win(IDX_AUX_A, RUN | GATD, 80); rd(cn(IDX_AUX_A)); `CHK(rd_v, 16'h000A)
    wr(cc(IDX_AUX_B), RUN | CNTR);
    for (int k = 0; k < 5; k++) u_gptu_pins.pulse_gate(2);
    wr(cc(IDX_AUX_B), 16'h0000); rd(cn(IDX_AUX_B)); `CHK(rd_v, 16'h0005)
    // Core wrap: latch, chained aux, request flag
    wr(cn(IDX_CORE1), 16'hFFFE); wr(cn(IDX_AUX_A), 16'h0000);
    wr(cc(IDX_AUX_A), RUN | AUXS);
    win(IDX_CORE1, RUN, 24); rd(cn(IDX_CORE1)); `CHK(rd_v, 16'h0001)
    `CHK(out1, 1'b1)
    rd(cn(IDX_AUX_A)); `CHK(rd_v, 16'h0001)
    rd(iq(IDX_CORE1)); `CHK(rd_v, 16'h0080)
    wr(iq(IDX_CORE1), 16'h00C5); rd(iq(IDX_CORE1)); `CHK(rd_v, 16'h00C5)
    `CHK(irq, 6'h02)
    wr(iq(IDX_CORE1), 16'h0045); rd(iq(IDX_CORE1)); `CHK(rd_v, 16'h0045)
    `CHK(irq, 6'h00)
    wr(cc(IDX_AUX_A), 16'h0000);
    // Capture and reload roles of the aux timers
    wr(cn(IDX_CORE1), 16'h1234); wr(cn(IDX_AUX_B), 16'h0000); wr(cc(IDX_AUX_B), RUN | CAPT);
    u_gptu_pins.pulse_gate(2); rd(cn(IDX_AUX_B)); `CHK(rd_v, 16'h1234)
    wr(cn(IDX_AUX_A), 16'h5555); wr(cc(IDX_AUX_A), RUN | RLD | TRGP);
    u_gptu_pins.pulse_gate(0); rd(cn(IDX_CORE1)); `CHK(rd_v, 16'h5555)
    rd(cn(IDX_AUX_A)); `CHK(rd_v, 16'h5555)
    wr(cc(IDX_AUX_A), 16'h0000); wr(cc(IDX_AUX_B), 16'h0000);
    // Capture into the capture/reload register with clear
    wr(cn(IDX_AUX2), 16'h0ABC); wr(cc(IDX_AUX2), TRGR | CLRC);
    u_gptu_pins.pulse_cap();
    rd(ADDR_CAPTURE_RELOAD_REGISTER); `CHK(rd_v, 16'h0ABC)
    rd(cn(IDX_AUX2)); `CHK(rd_v, 16'h0000)
    rd(iq(IDX_CAP)); `CHK(rd_v, 16'h0080)
    // Second core wrap: reload, compare unit clock, latch
    wr(iq(IDX_CORE2), 16'h0040); wr(cn(IDX_CORE2), 16'hFFFF);
    win(IDX_CORE2, RUN | AUXS, 8); rd(cn(IDX_CORE2)); `CHK(rd_v, 16'h0ABD)
    `CHK(n_cc, 1)
    `CHK(out2, 1'b1)
    `CHK(irq, 6'h10)
    // Alternating reloads from both aux timers give a PWM waveform
    wr(cn(IDX_AUX_A), 16'h0001); wr(cn(IDX_AUX_B), 16'h0002); wr(cn(IDX_CORE1), 16'h0000);
    wr(cc(IDX_AUX_A), RLD | TRGR); wr(cc(IDX_AUX_B), RLD | TRGF);
    win(IDX_CORE1, RUN | DOWN, 56); rd(cn(IDX_CORE1)); `CHK(rd_v, 16'h0001)
    `CHK(out1, 1'b0)
    test_done();
  end
endmodule // test_general_purpose_timer_unit
